// ### hw/tmc_defines.svh
// constants of the 16-bit timer/event counter: offsets, fields, resets
// assumes inclusion by tmc_timer and by the bench
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

`define TMC_OFS_MODE 8'h00
`define TMC_OFS_PRM 8'h04
`define TMC_OFS_CAPC 8'h08
`define TMC_OFS_OSC 8'h0c
`define TMC_OFS_CNT 8'h10
`define TMC_OFS_CCA 8'h14
`define TMC_OFS_CCB 8'h18
`define TMC_OFS_IST 8'h1c
`define TMC_OFS_IMSK 8'h20

`define TMC_MODE_OVF_BIT 0
`define TMC_MODE_LO_BIT 2
`define TMC_MODE_HI_BIT 3
`define TMC_PRM_PRESC_LSB 0
`define TMC_PRM_ESA_LSB 4
`define TMC_PRM_ESB_LSB 6
`define TMC_CAPC_A_BIT 0
`define TMC_CAPC_B_BIT 1
`define TMC_OSC_EN_BIT 0
`define TMC_OSC_TI_BIT 1
`define TMC_OSC_SWTRIG_BIT 2
`define TMC_IST_A_BIT 0
`define TMC_IST_B_BIT 1
`define TMC_IST_OVF_BIT 2

`define TMC_OPM_STOP 2'h0
`define TMC_OPM_FREE 2'h1
`define TMC_OPM_TIEDGE 2'h2
`define TMC_OPM_MATCH 2'h3

`define TMC_ES_FALL 2'h0
`define TMC_ES_RISE 2'h1
`define TMC_ES_NONE 2'h2
`define TMC_ES_BOTH 2'h3

`define TMC_CNT_MAX 16'hffff
`define TMC_RST_CFG 12'h000
`define TMC_RST_WORD 16'h0000

`endif

// ### hw/tmc_edge_det.sv
// pin synchroniser and valid-edge detector for one timer input
// assumes pin is asynchronous to clk
`include "tmc_defines.svh"
module tmc_edge_det (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    input wire logic enable,
    output logic edge_pulse
);
    logic sync1_ff, sync2_ff, prev_ff;
    wire rise = sync2_ff && !prev_ff;
    wire fall = !sync2_ff && prev_ff;
    wire hit = (edge_sel == `TMC_ES_RISE) ? rise :
               (edge_sel == `TMC_ES_FALL) ? fall :
               (edge_sel == `TMC_ES_BOTH) ? (rise || fall) : 1'b0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
            edge_pulse <= 1'b0;
        end
        else
        begin
            sync1_ff <= pin;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            edge_pulse <= enable && hit;
        end
    end
endmodule

// ### hw/tmc_pkg.sv
// types of the 16-bit timer/event counter
// assumes tmc_defines.svh for the field values
package tmc_pkg;
    typedef struct packed {
        logic [1:0] op_mode;
        logic [1:0] presc;
        logic [1:0] es_a;
        logic [1:0] es_b;
        logic cap_a;
        logic cap_b;
        logic os_en;
        logic os_ti;
    } tmc_cfg_t;

    typedef enum logic [1:0] {
        OS_IDLE,
        OS_ARMED,
        OS_ACTIVE
    } tmc_os_state_t;
endpackage

// ### hw/tmc_timer.sv
// 16-bit timer/event counter with two compare/capture registers
// assumes a single-cycle register port master on clk
`include "tmc_defines.svh"
module tmc_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    input wire logic timer_input_a,
    input wire logic timer_input_b,
    output logic pulse_out,
    output logic capture_match_irq_a,
    output logic capture_match_irq_b,
    output logic irq
);
    import tmc_pkg::*;

    tmc_cfg_t cfg_ff, nxt_cfg;
    tmc_os_state_t os_st_ff, nxt_os_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] compare_capture_reg_a, nxt_cca;
    logic [15:0] compare_capture_reg_b, nxt_ccb;
    logic [2:0] div_ff;
    logic overflow_flag, nxt_ovf;
    logic ovf_hold_ff;
    logic [2:0] ist_ff, nxt_ist, imsk_ff;
    logic edge_a, edge_b;

    // bus decode
    wire wr_mode = bus_wr && bus_addr == `TMC_OFS_MODE;
    wire wr_prm = bus_wr && bus_addr == `TMC_OFS_PRM;
    wire wr_capc = bus_wr && bus_addr == `TMC_OFS_CAPC;
    wire wr_osc = bus_wr && bus_addr == `TMC_OFS_OSC;
    wire wr_cca = bus_wr && bus_addr == `TMC_OFS_CCA;
    wire wr_ccb = bus_wr && bus_addr == `TMC_OFS_CCB;
    wire wr_ist = bus_wr && bus_addr == `TMC_OFS_IST;
    wire wr_imsk = bus_wr && bus_addr == `TMC_OFS_IMSK;

    // mode and count clock
    wire run = cfg_ff.op_mode != `TMC_OPM_STOP;
    wire m_match = cfg_ff.op_mode == `TMC_OPM_MATCH;
    wire m_tiedge = cfg_ff.op_mode == `TMC_OPM_TIEDGE;
    wire [2:0] presc_mask = 3'(~(3'h7 << cfg_ff.presc));
    wire tick = run && ((div_ff & presc_mask) == presc_mask);

    tmc_edge_det u_edge_a (
        .clk(clk),
        .rst_n(rst_n),
        .pin(timer_input_a),
        .edge_sel(cfg_ff.es_a),
        .enable(run),
        .edge_pulse(edge_a)
    );

    tmc_edge_det u_edge_b (
        .clk(clk),
        .rst_n(rst_n),
        .pin(timer_input_b),
        .edge_sel(cfg_ff.es_b),
        .enable(run),
        .edge_pulse(edge_b)
    );

    // compare match; a zero value in reg a never matches in match mode
    wire zero_a = compare_capture_reg_a == `TMC_RST_WORD;
    wire match_a = cnt_ff == compare_capture_reg_a
                   && !(m_match && zero_a);
    wire match_b = cnt_ff == compare_capture_reg_b;
    wire cmp_a_evt = tick && !cfg_ff.cap_a && match_a;
    wire cmp_b_evt = tick && !cfg_ff.cap_b && match_b;
    // captures ignore the read strobe
    wire cap_a_evt = run && cfg_ff.cap_a && edge_b;
    wire cap_b_evt = run && cfg_ff.cap_b && edge_a;
    wire ev_a = cmp_a_evt || cap_a_evt;
    wire ev_b = cmp_b_evt || cap_b_evt;
    // also covers match clear at the top value
    wire ovf_evt = tick && cnt_ff == `TMC_CNT_MAX;
    wire clr_edge = m_tiedge && edge_a;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (!run)
            nxt_cnt = `TMC_RST_WORD;
        else if (clr_edge)
            nxt_cnt = `TMC_RST_WORD;
        else if (tick)
            nxt_cnt = (m_match && cmp_a_evt) ? `TMC_RST_WORD
                                             : 16'(cnt_ff + 16'h1);
    end

    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (wr_mode)
            nxt_cfg.op_mode = bus_wdata[`TMC_MODE_HI_BIT:`TMC_MODE_LO_BIT];
        if (wr_prm)
        begin
            nxt_cfg.presc = bus_wdata[`TMC_PRM_PRESC_LSB +: 2];
            nxt_cfg.es_a = bus_wdata[`TMC_PRM_ESA_LSB +: 2];
            nxt_cfg.es_b = bus_wdata[`TMC_PRM_ESB_LSB +: 2];
        end
        if (wr_capc)
        begin
            nxt_cfg.cap_a = bus_wdata[`TMC_CAPC_A_BIT];
            nxt_cfg.cap_b = bus_wdata[`TMC_CAPC_B_BIT];
        end
        if (wr_osc)
        begin
            nxt_cfg.os_en = bus_wdata[`TMC_OSC_EN_BIT];
            nxt_cfg.os_ti = bus_wdata[`TMC_OSC_TI_BIT];
        end
    end

    // capture wins over a write; capture registers read zero when stopped
    always_comb
    begin
        nxt_cca = compare_capture_reg_a;
        nxt_ccb = compare_capture_reg_b;
        if (cap_a_evt)
            nxt_cca = cnt_ff;
        else if (!run && cfg_ff.cap_a)
            nxt_cca = `TMC_RST_WORD;
        else if (wr_cca)
            nxt_cca = bus_wdata;
        if (cap_b_evt)
            nxt_ccb = cnt_ff;
        else if (!run && cfg_ff.cap_b)
            nxt_ccb = `TMC_RST_WORD;
        else if (wr_ccb)
            nxt_ccb = bus_wdata;
    end

    // overflow: set wins, clear ignored until the next count clock
    wire ovf_clr = wr_mode && !bus_wdata[`TMC_MODE_OVF_BIT] && !ovf_hold_ff;
    assign nxt_ovf = ovf_evt || (overflow_flag && !ovf_clr);
    wire [2:0] ev_vec = {ovf_evt, ev_b, ev_a};
    wire [2:0] w1c = wr_ist ? bus_wdata[2:0] : 3'h0;
    assign nxt_ist = (ist_ff & ~w1c) | ev_vec;

    // one-shot pulse: armed by trigger, high from match b to match a
    wire os_ok = cfg_ff.os_en && run && !m_match;
    wire sw_trig = wr_osc && bus_wdata[`TMC_OSC_SWTRIG_BIT];
    wire os_trig = sw_trig || (cfg_ff.os_ti && edge_a);

    always_comb
    begin
        nxt_os_st = os_st_ff;
        case (os_st_ff)
            OS_IDLE:
                if (os_trig)
                    nxt_os_st = OS_ARMED;
            OS_ARMED:
                if (tick && match_b)
                    nxt_os_st = OS_ACTIVE;
            OS_ACTIVE:
                if (tick && match_a)
                    nxt_os_st = OS_IDLE;
            default:
                nxt_os_st = OS_IDLE;
        endcase
        if (!os_ok)
            nxt_os_st = OS_IDLE;
    end

    // read mux
    wire [15:0] mode_rd = {12'h000, cfg_ff.op_mode, 1'b0, overflow_flag};
    wire [15:0] prm_rd = {8'h00, cfg_ff.es_b, cfg_ff.es_a, 2'h0, cfg_ff.presc};
    wire [15:0] rsel =
        (bus_addr == `TMC_OFS_MODE) ? mode_rd :
        (bus_addr == `TMC_OFS_PRM) ? prm_rd :
        (bus_addr == `TMC_OFS_CAPC) ? {14'h0, cfg_ff.cap_b, cfg_ff.cap_a} :
        (bus_addr == `TMC_OFS_OSC) ? {14'h0, cfg_ff.os_ti, cfg_ff.os_en} :
        (bus_addr == `TMC_OFS_CNT) ? cnt_ff :
        (bus_addr == `TMC_OFS_CCA) ? compare_capture_reg_a :
        (bus_addr == `TMC_OFS_CCB) ? compare_capture_reg_b :
        (bus_addr == `TMC_OFS_IST) ? {13'h0, ist_ff} :
        (bus_addr == `TMC_OFS_IMSK) ? {13'h0, imsk_ff} : 16'h0000;

    assign irq = |(ist_ff & imsk_ff);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_ff <= `TMC_RST_CFG;
            cnt_ff <= `TMC_RST_WORD;
            compare_capture_reg_a <= `TMC_RST_WORD;
            compare_capture_reg_b <= `TMC_RST_WORD;
            div_ff <= 3'h0;
            overflow_flag <= 1'b0;
            ovf_hold_ff <= 1'b0;
            ist_ff <= 3'h0;
            imsk_ff <= 3'h0;
            os_st_ff <= OS_IDLE;
            pulse_out <= 1'b0;
            bus_rdata <= 16'h0000;
            capture_match_irq_a <= 1'b0;
            capture_match_irq_b <= 1'b0;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            cnt_ff <= nxt_cnt;
            compare_capture_reg_a <= nxt_cca;
            compare_capture_reg_b <= nxt_ccb;
            div_ff <= run ? 3'(div_ff + 3'h1) : 3'h0;
            overflow_flag <= nxt_ovf;
            ovf_hold_ff <= ovf_evt || (ovf_hold_ff && !tick);
            ist_ff <= nxt_ist;
            imsk_ff <= wr_imsk ? bus_wdata[2:0] : imsk_ff;
            os_st_ff <= nxt_os_st;
            pulse_out <= nxt_os_st == OS_ACTIVE;
            bus_rdata <= bus_rd ? rsel : 16'h0000;
            capture_match_irq_a <= ev_a;
            capture_match_irq_b <= ev_b;
        end
    end

    chk_ovf_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_evt |=> overflow_flag && ist_ff[`TMC_IST_OVF_BIT] && cnt_ff == 0)
        else $error("overflow not flagged on wrap");

    chk_ovf_hold: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_hold_ff && wr_mode && !bus_wdata[`TMC_MODE_OVF_BIT]
        |=> overflow_flag)
        else $error("overflow cleared before count reached one");

    chk_capture_read: assert property (@(posedge clk) disable iff (!rst_n)
        cap_a_evt && bus_rd |=> compare_capture_reg_a == $past(cnt_ff)
            && ist_ff[`TMC_IST_A_BIT] && capture_match_irq_a
            ##1 !capture_match_irq_a)
        else $error("capture lost during read");

    chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !clr_edge && !(m_match && cmp_a_evt)
        |=> cnt_ff == 16'($past(cnt_ff) + 16'h1))
        else $error("counter did not advance by one");

    chk_stop_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !run && !wr_mode |=> cnt_ff == 0 && !pulse_out)
        else $error("counter moved while stopped");

    chk_zero_nomatch: assert property (@(posedge clk) disable iff (!rst_n)
        tick && m_match && zero_a && !cfg_ff.cap_a && !edge_a
        && cnt_ff != `TMC_CNT_MAX |=> cnt_ff != 0)
        else $error("zero compare value cleared the counter");

    chk_cap_stopped: assert property (@(posedge clk) disable iff (!rst_n)
        !run && cfg_ff.cap_a && !cap_a_evt |=> compare_capture_reg_a == 0)
        else $error("capture register held value while stopped");

    chk_os_mode: assert property (@(posedge clk) disable iff (!rst_n)
        m_match |=> os_st_ff == OS_IDLE ##1 !pulse_out)
        else $error("one-shot active in match mode");
endmodule

// ### sim/tb_tmc_timer.sv
// self-checking bench for the 16-bit timer/event counter
// assumes tmc_timer, tmc_pulse_src and tmc_pkg compiled before
`include "tmc_defines.svh"
module tb_tmc_timer;
    timeunit 1ns;
    timeprecision 1ns;
    import tmc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fire_a = 1'b0;
    logic fire_b = 1'b0;
    int irqa_n = 0;
    int irqb_n = 0;
    int n0;
    logic [15:0] rdata;
    logic tia;
    logic tib;
    logic pulse;
    logic irqa;
    logic irqb;
    logic irq;
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] v;
    int error_cnt = 0;
    int cmp_count = 0;
    int n;
    always #20 clk = ~clk;
    tmc_pulse_src u_src (.clk(clk), .fire_a(fire_a), .fire_b(fire_b),
        .timer_input_a(tia), .timer_input_b(tib));
    tmc_timer u_dut (.clk(clk), .rst_n(rst_n), .bus_addr(addr),
        .bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
        .timer_input_a(tia), .timer_input_b(tib), .pulse_out(pulse),
        .capture_match_irq_a(irqa), .capture_match_irq_b(irqb),
        .irq(irq));
    // event pulses counted mid-cycle, where they are settled
    always @(negedge clk)
    begin
        if (irqa === 1'b1)
            irqa_n <= irqa_n + 1;
        if (irqb === 1'b1)
            irqb_n <= irqb_n + 1;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #(40 * 100000);
        error_cnt++;
        final_report;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`TMC_OFS_MODE, v);
        check("mode reset", v, 16'h0000);
        rd_reg(`TMC_OFS_CNT, v);
        check("cnt reset", v, 16'h0000);
        rd_reg(8'h30, v);
        check("unmapped", v, 16'h0000);
        wr_reg(`TMC_OFS_MODE, 16'h0004);
        rd_reg(`TMC_OFS_CNT, v0);
        rd_reg(`TMC_OFS_CNT, v1);
        check("count step", v1 - v0, 16'h0002);
        // capture of reg a on rising input b while reading it
        wr_reg(`TMC_OFS_MODE, 16'h0000);
        wr_reg(`TMC_OFS_PRM, 16'h0040);
        wr_reg(`TMC_OFS_CAPC, 16'h0001);
        wr_reg(`TMC_OFS_MODE, 16'h0004);
        rd_reg(`TMC_OFS_CNT, v0);
        // drop the compare events of the count start
        wr_reg(`TMC_OFS_IST, 16'h0007);
        n0 = irqa_n;
        fire_b <= 1'b1;
        @(posedge clk);
        fire_b <= 1'b0;
        n = 0;
        while (irqa_n == n0 && n < 20)
        begin
            rd_reg(`TMC_OFS_CCA, v);
            n++;
        end
        check("irq a", 16'(irqa_n - n0), 16'h0001);
        rd_reg(`TMC_OFS_CNT, v1);
        rd_reg(`TMC_OFS_CCA, v);
        check("cap value", 16'(v > v0 && v < v1), 16'h0001);
        rd_reg(`TMC_OFS_IST, v);
        check("status a", v, 16'h0001);
        check("irq masked", 16'(irq), 16'h0000);
        wr_reg(`TMC_OFS_IMSK, 16'h0001);
        #1 check("irq on", 16'(irq), 16'h0001);
        wr_reg(`TMC_OFS_IST, 16'h0001);
        #1 check("irq clr", 16'(irq), 16'h0000);
        // one-shot width per mode, none in match mode
        wr_reg(`TMC_OFS_MODE, 16'h0000);
        wr_reg(`TMC_OFS_CAPC, 16'h0000);
        wr_reg(`TMC_OFS_PRM, 16'h0000);
        for (int m = 1; m < 4; m++)
        begin
            wr_reg(`TMC_OFS_MODE, 16'h0000);
            // contents may be lost after stop, so reload
            wr_reg(`TMC_OFS_CCA, 16'h0040);
            wr_reg(`TMC_OFS_CCB, 16'h0020);
            wr_reg(`TMC_OFS_OSC, 16'h0001);
            wr_reg(`TMC_OFS_MODE, 16'(m << 2));
            wr_reg(`TMC_OFS_OSC, 16'h0005);
            n = 0;
            n0 = irqb_n;
            repeat (200)
            begin
                @(posedge clk);
                #1 n += (pulse === 1'b1);
            end
            check("os width", 16'(n), m == 3 ? 16'h0000 : 16'h0020);
            check("irq b", 16'(irqb_n - n0), 16'(m == 3 ? 3 : 1));
        end
        // wrap on match at maximum
        wr_reg(`TMC_OFS_MODE, 16'h0000);
        wr_reg(`TMC_OFS_CCA, `TMC_CNT_MAX);
        wr_reg(`TMC_OFS_IMSK, 16'h0004);
        wr_reg(`TMC_OFS_IST, 16'h0007);
        wr_reg(`TMC_OFS_MODE, 16'h000c);
        // clear lands in the cycle after the wrap, before count one
        repeat (65535) @(posedge clk);
        wr_reg(`TMC_OFS_MODE, 16'h000c);
        #1 check("ovf irq", 16'(irq), 16'h0001);
        rd_reg(`TMC_OFS_MODE, v);
        check("ovf flag", v, 16'h000d);
        rd_reg(`TMC_OFS_IST, v);
        check("ovf status", v & 16'h0004, 16'h0004);
        wr_reg(`TMC_OFS_MODE, 16'h000c);
        rd_reg(`TMC_OFS_MODE, v);
        check("ovf clear", v, 16'h000c);
        final_report;
    end
endmodule

// ### sim/tmc_pulse_src.sv
// pulse source model standing on the timer input pins
// assumes one request cycle per pulse; pins idle low
module tmc_pulse_src #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic fire_a,
    input wire logic fire_b,
    output logic timer_input_a,
    output logic timer_input_b
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_a = 0;
    int cnt_b = 0;
    // pulses six clocks wide: wider than two clocks, and than one count clock for presc up to 2
    always @(posedge clk)
    begin
        cnt_a <= fire_a ? W : (cnt_a > 0 ? cnt_a - 1 : 0);
        cnt_b <= fire_b ? W : (cnt_b > 0 ? cnt_b - 1 : 0);
    end
    assign timer_input_a = (cnt_a > 0);
    assign timer_input_b = (cnt_b > 0);
endmodule
